// ===== logic/cell_fault_qual.sv
// Purpose: Qualify a cell voltage fault over sampled measurements
// Assumes: sample pulses once per measurement interval
// Notes: Flag follows the samples, no latching beyond a good sample
module cell_fault_qual (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample,
  input wire logic fault_now,
  input wire logic need_two,
  output logic flag_q
);
  logic seen_q; // Previous sample was faulty

  // Evaluate only on sample strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
      flag_q <= 1'b0;
    end else if (sample) begin
      seen_q <= fault_now;
      // One faulty sample, or two in a row when qualified
      flag_q <= fault_now && (!need_two || seen_q);
    end
  end
endmodule

// ===== logic/charge_cfg_pkg.sv
// Purpose: Types shared by the charge-control block
// Assumes: Nothing beyond the constants header
// Notes: Charge sequencing states only
package charge_cfg_pkg;
  typedef enum logic [1:0] {
    CHG_IDLE = 2'b00, // Not charging
    CHG_FAST = 2'b01, // Fast charge running
    CHG_SUSP = 2'b10, // Suspended by a fault
    CHG_DONE = 2'b11  // Taper termination reached
  } chg_state_e;
endpackage

// ===== logic/charge_cfg_regs.svh
// Purpose: Offsets, field positions and timing counts of the charge block
// Assumes: Register index times four is the bus byte address
// Notes: Indices double as external memory byte addresses (low byte first)
`ifndef CHARGE_CFG_REGS_SVH
`define CHARGE_CFG_REGS_SVH
`define IDX_RTA 8'h02
`define IDX_RCA 8'h04
`define IDX_MOVR 8'h2e
`define IDX_CCT 8'h3c
`define IDX_PCFG 8'h3f
`define IDX_TLIM 8'h45
`define IDX_OCM 8'h49
`define IDX_CVL 8'h4a
`define IDX_FCT 8'h4b
`define IDX_FFC 8'h4c
`define IDX_CTT 8'h4e
`define IDX_CTQ 8'h4f
`define IDX_PPROG 8'h63
`define IDX_STATUS 8'h90
`define IDX_CYCLES 8'h91
`define IDX_CHG_REQ 8'h92
`define PCFG_DISPLAY 7
`define PCFG_LOCK 6
`define PCFG_RESYNC 5
`define PCFG_COMP 4
`define PCFG_MIDFIX 3
`define PCFG_THERM 2
`define PCFG_ONCEFIX 1
`define PCFG_FOUR 0
`define PPROG_QUAL 0
`define PPROG_BASIS 2
`define PPROG_FLOOR 3
`define PPROG_COLD 4
`define CLK_HZ 25000000
`define TICK_MS 1000
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`define TAPER_S 40
`define FAULT_S 2
`define MARGIN_MA 16
`define HOT_BASE_DC 690
`define HOT_STEP_DC 16
`define COLD_STEP_DC 8
`define LEARN_COLD_DC 120
`define OV_BASE_MV 4096
`define OV_STEP_MV 32
`define UV_BASE_MV 2048
`define UV_STEP_MV 64
`define TAPER_NUM 1125
`define RS_MOHM 20
`endif

// ===== logic/charge_control.sv
// Purpose: Charge control and pack option decode behind an AHB-Lite slave
// Assumes: Measurement inputs come from logic on hclk, no synchronising
// Notes: Reads take one wait state, writes none; response always OKAY
//
// The AHB-Lite register port was decided locally.
`include "charge_cfg_regs.svh"
module charge_control
  import charge_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int RS_MOHM = `RS_MOHM
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ee_wr,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_data,
  input wire logic ee_done,
  input wire logic charging,
  input wire logic signed [15:0] meas_current_ma,
  input wire logic [15:0] fast_current_ma,
  input wire logic [15:0] precharge_current_ma,
  input wire logic [15:0] pack_mv,
  input wire logic [15:0] charging_voltage_mv,
  input wire logic signed [15:0] temp_dc,
  input wire logic [7:0] rsoc,
  input wire logic [15:0] full_charge_capacity,
  input wire logic chg_mah_pulse,
  input wire logic dsg_mah_pulse,
  input wire logic [15:0] run_time_min,
  input wire logic [15:0] remaining_capacity,
  input wire logic [15:0] cell_max_mv,
  input wire logic [15:0] cell_min_mv,
  input wire logic [7:0] smb_cmd,
  output logic cmd_rd_ok,
  output logic cmd_wr_ok,
  output logic [15:0] charge_request_ma,
  output logic full_flag,
  output logic rm_load,
  output logic [15:0] rm_load_value,
  output logic [15:0] cycle_count,
  output logic time_alarm,
  output logic capacity_alarm,
  output logic cell_under_flag,
  output logic cell_over_flag,
  output logic [15:0] cell_high_limit,
  output logic [15:0] cell_low_limit,
  output logic [15:0] learn_current_floor,
  output logic signed [15:0] learn_cold_limit,
  output logic display_source_select,
  output logic compensated_threshold_enable,
  output logic continuous_midrange_fix,
  output logic external_thermistor_select,
  output logic single_midrange_fix,
  output logic four_series_select,
  output logic discharge_end_basis
);
  // Configuration image
  logic [15:0] rta_q, rca_q, movr_q, cct_q; // Word settings
  logic [7:0] pcfg_q, tlim_q, ocm_q, cvl_q; // Byte settings
  logic [7:0] fct_q, ffc_q, ctt_q, ctq_q, pprog_q;
  logic loaded_q; // Configuration image complete
  logic access_lock_q; // Lock state caught at load
  logic once_q; // One-time correction already issued
  // Bus state
  logic wr_pend_q, rd_pend_q; // Data phase kinds
  logic [7:0] idx_q; // Register index of data phase
  // Charge state
  chg_state_e state_q;
  logic [15:0] ovr_cnt_q; // Charge added past full
  logic [15:0] dsg_cnt_q; // Discharge since last cycle
  logic [5:0] taper_s_q; // Seconds of qualified taper
  logic sec_tick; // One-second enable
  logic half_q; // Divides seconds into fault samples
  logic fault_tick; // Fault sampling enable

  // Command window check used for both access kinds
  function automatic logic in_rng(input logic [7:0] c, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (c >= lo) && (c <= hi);
  endfunction

  // Bus slave: address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= 8'h0;
    end else if (hready && hreadyout) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      rd_pend_q <= hsel && htrans[1] && !hwrite;
      idx_q <= haddr[9:2];
    end else begin
      // Read wait state ends after one cycle
      rd_pend_q <= 1'b0;
    end
  end

  // Read takes one wait state so data come from a flop
  assign hreadyout = !rd_pend_q;
  assign hresp = 1'b0;

  // Read data register; unmapped indices read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_pend_q) begin
      case (idx_q)
        `IDX_RTA: hrdata <= {16'h0, rta_q};
        `IDX_RCA: hrdata <= {16'h0, rca_q};
        `IDX_MOVR: hrdata <= {16'h0, movr_q};
        `IDX_CCT: hrdata <= {16'h0, cct_q};
        `IDX_PCFG: hrdata <= {24'h0, pcfg_q};
        `IDX_TLIM: hrdata <= {24'h0, tlim_q};
        `IDX_OCM: hrdata <= {24'h0, ocm_q};
        `IDX_CVL: hrdata <= {24'h0, cvl_q};
        `IDX_FCT: hrdata <= {24'h0, fct_q};
        `IDX_FFC: hrdata <= {24'h0, ffc_q};
        `IDX_CTT: hrdata <= {24'h0, ctt_q};
        `IDX_CTQ: hrdata <= {24'h0, ctq_q};
        `IDX_PPROG: hrdata <= {24'h0, pprog_q};
        `IDX_STATUS: hrdata <= {24'h0, cell_over_flag, cell_under_flag,
                                access_lock_q, full_flag, 1'b0,
                                state_q, loaded_q};
        `IDX_CYCLES: hrdata <= {16'h0, cycle_count};
        `IDX_CHG_REQ: hrdata <= {16'h0, charge_request_ma};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Configuration writes from external memory bytes or the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rta_q, rca_q, movr_q, cct_q} <= 64'h0;
      {pcfg_q, tlim_q, ocm_q, cvl_q, fct_q} <= 40'h0;
      {ffc_q, ctt_q, ctq_q, pprog_q} <= 32'h0;
    end else if (ee_wr) begin
      case (ee_addr)
        `IDX_RTA: rta_q[7:0] <= ee_data;
        `IDX_RTA + 8'h1: rta_q[15:8] <= ee_data;
        `IDX_RCA: rca_q[7:0] <= ee_data;
        `IDX_RCA + 8'h1: rca_q[15:8] <= ee_data;
        `IDX_MOVR: movr_q[7:0] <= ee_data;
        `IDX_MOVR + 8'h1: movr_q[15:8] <= ee_data;
        `IDX_CCT: cct_q[7:0] <= ee_data;
        `IDX_CCT + 8'h1: cct_q[15:8] <= ee_data;
        `IDX_PCFG: pcfg_q <= ee_data;
        `IDX_TLIM: tlim_q <= ee_data;
        `IDX_OCM: ocm_q <= ee_data;
        `IDX_CVL: cvl_q <= ee_data;
        `IDX_FCT: fct_q <= ee_data;
        `IDX_FFC: ffc_q <= ee_data;
        `IDX_CTT: ctt_q <= ee_data;
        `IDX_CTQ: ctq_q <= ee_data;
        `IDX_PPROG: pprog_q <= ee_data;
        default: ;
      endcase
    end else if (wr_pend_q) begin
      case (idx_q)
        `IDX_RTA: rta_q <= hwdata[15:0];
        `IDX_RCA: rca_q <= hwdata[15:0];
        `IDX_MOVR: movr_q <= hwdata[15:0];
        `IDX_CCT: cct_q <= hwdata[15:0];
        `IDX_PCFG: pcfg_q <= hwdata[7:0];
        `IDX_TLIM: tlim_q <= hwdata[7:0];
        `IDX_OCM: ocm_q <= hwdata[7:0];
        `IDX_CVL: cvl_q <= hwdata[7:0];
        `IDX_FCT: fct_q <= hwdata[7:0];
        `IDX_FFC: ffc_q <= hwdata[7:0];
        `IDX_CTT: ctt_q <= hwdata[7:0];
        `IDX_CTQ: ctq_q <= hwdata[7:0];
        `IDX_PPROG: pprog_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Load completion; lock state sampled here only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loaded_q <= 1'b0;
      access_lock_q <= 1'b0;
    end else if (ee_done && !loaded_q) begin
      loaded_q <= 1'b1;
      access_lock_q <= pcfg_q[`PCFG_LOCK];
    end
  end

  // Single midrange correction pulse once after load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      once_q <= 1'b0;
      single_midrange_fix <= 1'b0;
    end else begin
      single_midrange_fix <= loaded_q && !once_q &&
                             pcfg_q[`PCFG_ONCEFIX];
      if (loaded_q) once_q <= 1'b1;
    end
  end

  // Command access windows; unlocked grants all commands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_rd_ok <= 1'b0;
      cmd_wr_ok <= 1'b0;
    end else begin
      cmd_wr_ok <= !access_lock_q || in_rng(smb_cmd, 8'h00, 8'h04) ||
                   smb_cmd == 8'h2f || in_rng(smb_cmd, 8'h3c, 8'h3f);
      cmd_rd_ok <= !access_lock_q || in_rng(smb_cmd, 8'h00, 8'h04) ||
                   in_rng(smb_cmd, 8'h05, 8'h1c) ||
                   in_rng(smb_cmd, 8'h20, 8'h23) || smb_cmd == 8'h2f ||
                   in_rng(smb_cmd, 8'h3c, 8'h3f);
    end
  end

  // Slow time base: seconds and two-second fault samples
  tick_gen #(.CYCLES(TICK_CYCLES)) u_sec (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(sec_tick)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) half_q <= 1'b0;
    else if (sec_tick) half_q <= !half_q;
  end
  assign fault_tick = sec_tick && half_q;

  // Charge decisions
  logic [17:0] oc_limit; // Request plus margin
  logic over_current, over_temp, over_charge, cold_window;
  logic volt_ok, cur_ok, taper_ok;
  logic signed [15:0] hot_dc, cold_dc;
  // Margin rides on whichever current is being requested
  assign oc_limit = {2'b00, cold_window ? precharge_current_ma :
                    fast_current_ma} +
                    18'(ocm_q) * 18'(`MARGIN_MA);
  assign over_current = !meas_current_ma[15] &&
                        {2'b00, meas_current_ma} > oc_limit;
  assign hot_dc = 16'(`HOT_BASE_DC) -
                  16'(tlim_q[7:4]) * 16'(`HOT_STEP_DC);
  assign over_temp = temp_dc >= hot_dc;
  assign cold_dc = 16'(tlim_q[3:0]) * 16'(`COLD_STEP_DC);
  assign cold_window = !temp_dc[15] && temp_dc < cold_dc;
  assign over_charge = ovr_cnt_q > 16'(-movr_q);
  assign volt_ok = {1'b0, pack_mv} + {8'h0, ctq_q, 1'b0} >
                   {1'b0, charging_voltage_mv};
  assign cur_ok = !meas_current_ma[15] &&
                  32'(meas_current_ma) * 32'(RS_MOHM) * 32'd2 <
                  32'(ctt_q) * 32'(`TAPER_NUM);
  assign taper_ok = volt_ok && cur_ok;

  // Charge state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CHG_IDLE;
    end else if (!loaded_q || !charging) begin
      state_q <= CHG_IDLE;
    end else begin
      case (state_q)
        CHG_IDLE: state_q <= CHG_FAST;
        CHG_FAST: begin
          if (over_current || over_temp || over_charge)
            state_q <= CHG_SUSP;
          else if (taper_s_q == 6'(`TAPER_S))
            state_q <= CHG_DONE;
        end
        CHG_SUSP: ; // Held until charging ends
        CHG_DONE: ; // Held until charging ends
        default: state_q <= CHG_IDLE;
      endcase
    end
  end

  // Requested charge current, zero in suspension or after termination
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charge_request_ma <= 16'h0;
    end else if (state_q != CHG_FAST || over_current) begin
      charge_request_ma <= 16'h0;
    end else if (cold_window) begin
      charge_request_ma <= precharge_current_ma;
    end else begin
      charge_request_ma <= fast_current_ma;
    end
  end

  // Seconds of continuous taper qualification
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) taper_s_q <= 6'h0;
    else if (state_q != CHG_FAST || !taper_ok) taper_s_q <= 6'h0;
    else if (sec_tick && taper_s_q != 6'(`TAPER_S))
      taper_s_q <= taper_s_q + 6'h1;
  end

  // Full flag: termination sets, clear level clears, set wins
  logic term_now;
  assign term_now = state_q == CHG_FAST && taper_s_q == 6'(`TAPER_S);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) full_flag <= 1'b0;
    else if (term_now) full_flag <= 1'b1;
    else if (loaded_q && rsoc <= 8'(-ffc_q)) full_flag <= 1'b0;
  end

  // Charge added past full during fast charge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ovr_cnt_q <= 16'h0;
    else if (!full_flag) ovr_cnt_q <= 16'h0;
    else if (chg_mah_pulse && state_q == CHG_FAST && ovr_cnt_q != 16'hffff)
      ovr_cnt_q <= ovr_cnt_q + 16'h1;
  end

  // Remaining capacity resync at termination
  logic [24:0] fill;
  assign fill = 25'(full_charge_capacity) * 25'({1'b0, fct_q} + 9'h1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rm_load <= 1'b0;
      rm_load_value <= 16'h0;
    end else begin
      rm_load <= term_now && pcfg_q[`PCFG_RESYNC];
      rm_load_value <= fill[23:8];
    end
  end

  // Cycle counting on discharged charge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dsg_cnt_q <= 16'h0;
      cycle_count <= 16'h0;
    end else if (loaded_q && dsg_mah_pulse) begin
      if (dsg_cnt_q + 16'h1 >= 16'(-cct_q)) begin
        dsg_cnt_q <= 16'h0;
        cycle_count <= cycle_count + 16'h1;
      end else begin
        dsg_cnt_q <= dsg_cnt_q + 16'h1;
      end
    end
  end

  // Alarm comparisons against stored thresholds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_alarm <= 1'b0;
      capacity_alarm <= 1'b0;
    end else begin
      time_alarm <= loaded_q && run_time_min < rta_q;
      capacity_alarm <= loaded_q && remaining_capacity < rca_q;
    end
  end

  // Cell limits and learning limits decoded from stored bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_high_limit <= 16'h0;
      cell_low_limit <= 16'h0;
      learn_current_floor <= 16'h0;
      learn_cold_limit <= 16'sh0;
    end else begin
      cell_high_limit <= 16'(`OV_BASE_MV) +
                         16'(cvl_q[3:0]) * 16'(`OV_STEP_MV);
      cell_low_limit <= 16'(`UV_BASE_MV) +
                        16'(cvl_q[7:4]) * 16'(`UV_STEP_MV);
      learn_current_floor <= pprog_q[`PPROG_FLOOR] ?
          16'(full_charge_capacity >> 5) :
          16'((18'(full_charge_capacity) * 18'd3) >> 5);
      learn_cold_limit <= pprog_q[`PPROG_COLD] ? cold_dc :
                          16'(`LEARN_COLD_DC);
    end
  end

  // Cell fault flags sampled every two seconds
  cell_fault_qual u_under (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(fault_tick && loaded_q),
    .fault_now(cell_min_mv < cell_low_limit),
    .need_two(pprog_q[`PPROG_QUAL]),
    .flag_q(cell_under_flag)
  );
  cell_fault_qual u_over (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample(fault_tick && loaded_q),
    .fault_now(cell_max_mv > cell_high_limit),
    .need_two(pprog_q[`PPROG_QUAL]),
    .flag_q(cell_over_flag)
  );

  // Option selects straight from the stored bytes
  assign display_source_select = pcfg_q[`PCFG_DISPLAY];
  assign compensated_threshold_enable = pcfg_q[`PCFG_COMP];
  assign continuous_midrange_fix = pcfg_q[`PCFG_MIDFIX];
  assign external_thermistor_select = pcfg_q[`PCFG_THERM];
  assign four_series_select = pcfg_q[`PCFG_FOUR];
  assign discharge_end_basis = pprog_q[`PPROG_BASIS];
endmodule

// ===== logic/tick_gen.sv
// Purpose: One-cycle enable pulse every CYCLES clocks
// Assumes: CYCLES of at least two
// Notes: Sole slow time base of the block
module tick_gen #(
  parameter int CYCLES = 25000000
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tick
);
  logic [31:0] cnt_q; // Cycles since last pulse

  generate
    if (CYCLES < 2) begin : g_bad
      $error("tick_gen needs CYCLES of two or more");
    end
  endgenerate

  // Free-running count, pulse on wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ===== testbench/cfg_rom.sv
// Purpose: Model of the configuration memory feeding the block
// Assumes: Loads once after reset, GAP idle cycles between bytes
// Notes: Idle data lines toggle so no stale byte looks valid
module cfg_rom #(
  parameter int GAP = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic ee_wr,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_data,
  output logic ee_done
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 17;
  // Address and byte pairs, first entry at the top
  localparam logic [N*16-1:0] ROM = {16'h021e, 16'h0300, 16'h04c8,
    16'h0500, 16'h3cfd, 16'h3dff, 16'h3f62, 16'h4500, 16'h4902,
    16'h4a5a, 16'h4b7f, 16'h4cfb, 16'h4e10, 16'h4f32, 16'h6300,
    16'h2e9c, 16'h2fff};
  logic [4:0] idx_q; // Next table entry
  logic [7:0] gap_q; // Idle cycles left
  // Walk the table, then announce completion once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q <= 5'h0;
      gap_q <= 8'h0;
      ee_wr <= 1'b0;
      ee_done <= 1'b0;
      ee_addr <= 8'h0;
      ee_data <= 8'h0;
    end else begin
      ee_wr <= 1'b0;
      ee_done <= 1'b0;
      ee_data <= ~ee_data;
      if (gap_q != 8'h0) begin
        gap_q <= gap_q - 8'h1;
      end else if (idx_q < 5'(N)) begin
        ee_wr <= 1'b1;
        ee_addr <= ROM[16*(N-1-int'(idx_q))+8 +: 8];
        ee_data <= ROM[16*(N-1-int'(idx_q)) +: 8];
        idx_q <= idx_q + 5'h1;
        gap_q <= 8'(GAP);
      end else if (idx_q == 5'(N)) begin
        ee_done <= 1'b1; // Only after every byte
        idx_q <= idx_q + 5'h1;
      end
    end
  end
endmodule

// ===== testbench/charge_control_asserts.sv
// Purpose: Port-level checks of the charge block
// Assumes: One clock domain, reset active low
// Notes: Limit bytes are seen only through memory load writes
module charge_control_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ee_wr,
  input wire logic [7:0] ee_addr,
  input wire logic [7:0] ee_data,
  input wire logic charging,
  input wire logic signed [15:0] meas_current_ma,
  input wire logic [15:0] fast_current_ma,
  input wire logic [15:0] precharge_current_ma,
  input wire logic [7:0] smb_cmd,
  input wire logic cmd_rd_ok,
  input wire logic cmd_wr_ok,
  input wire logic [15:0] charge_request_ma,
  input wire logic [15:0] cycle_count,
  input wire logic single_midrange_fix,
  input wire logic rm_load,
  input wire logic [15:0] cell_high_limit,
  input wire logic [15:0] cell_low_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] cvl_q; // Last cell limit byte loaded
  // Shadow of the limit byte, so the decode can be judged later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cvl_q <= 8'h00;
    end else if (ee_wr && ee_addr == 8'h4a) begin
      cvl_q <= ee_data;
    end
  end
  AST_CELL_HIGH: assert property (
    (ee_wr && ee_addr == 8'h4a) |->
    ##3 cell_high_limit == 16'd4096 + 16'(cvl_q[3:0]) * 16'd32)
    else $error("cell high limit decode wrong");
  AST_CELL_LOW: assert property (
    (ee_wr && ee_addr == 8'h4a) |->
    ##3 cell_low_limit == 16'd2048 + 16'(cvl_q[7:4]) * 16'd64)
    else $error("cell low limit decode wrong");
  // Current far above any request plus the widest margin
  AST_OVERCUR: assert property (
    (charging && int'(meas_current_ma) > int'(fast_current_ma) +
     int'(precharge_current_ma) + 4080) |-> ##3 charge_request_ma == 16'h0)
    else $error("charge request not zeroed");
  AST_RD_OK: assert property (
    smb_cmd inside {[8'h05:8'h1c], [8'h20:8'h23]} |=> cmd_rd_ok)
    else $error("readable command refused");
  AST_WR_OK: assert property (
    smb_cmd inside {[8'h00:8'h04], 8'h2f, [8'h3c:8'h3f]} |=> cmd_wr_ok)
    else $error("writable command refused");
  AST_ONCE_PULSE: assert property (
    single_midrange_fix |=> !single_midrange_fix [*8])
    else $error("one-shot correction repeated");
  AST_RM_PULSE: assert property (
    rm_load |=> !rm_load)
    else $error("capacity load longer than one cycle");
  AST_CYCLE_STEP: assert property (
    cycle_count != $past(cycle_count) |->
    cycle_count == $past(cycle_count) + 16'd1)
    else $error("cycle count jumped");
endmodule

// ===== testbench/charge_control_pack_config_bench.sv
// Purpose: Self-checking bench of the charge block
// Assumes: Ten-cycle tick, configuration from the memory model
// Notes: Bus master holds each phase until ready is sampled high
module charge_control_pack_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, charging = 0;
  logic chg_mah_pulse = 0, dsg_mah_pulse = 0, hready;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic signed [15:0] meas_current_ma = 0, temp_dc = 250, learn_cold_limit;
  logic [15:0] fast_current_ma = 0, precharge_current_ma = 100;
  logic [15:0] pack_mv = 12550, charging_voltage_mv = 12600;
  logic [15:0] full_charge_capacity = 2000, run_time_min = 90;
  logic [15:0] remaining_capacity = 900, cell_max_mv = 4000;
  logic [15:0] cell_min_mv = 3000, charge_request_ma, rm_load_value;
  logic [15:0] cycle_count, cell_high_limit, cell_low_limit;
  logic [15:0] learn_current_floor;
  logic [7:0] rsoc = 90, smb_cmd = 0, ee_addr, ee_data;
  logic hreadyout, hresp, cmd_rd_ok, cmd_wr_ok, full_flag, rm_load;
  logic ee_wr, ee_done, time_alarm, capacity_alarm;
  logic cell_under_flag, cell_over_flag, display_source_select;
  logic compensated_threshold_enable, continuous_midrange_fix;
  logic external_thermistor_select, single_midrange_fix;
  logic four_series_select, discharge_end_basis;
  int error_cnt = 0, compares = 0, once_cnt = 0, n;
  assign hready = hreadyout; // One slave owns the bus ready
  charge_control #(.TICK_CYCLES(10)) dut (.*);
  cfg_rom #(.GAP(1)) rom (.*);
  initial forever #20 hclk = ~hclk;
  // Count one-shot correction pulses
  always @(posedge hclk) if (single_midrange_fix === 1'b1) once_cnt++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // Bounded wait for the slave to be ready
  task rdy;
    int m;
    m = 0;
    do begin
      @(posedge hclk);
      m++;
    end while (hreadyout !== 1'b1 && m < 50);
    if (m >= 50) begin
      error_cnt++;
      close_out;
    end
  endtask
  task bus(input logic w, input logic [7:0] ix, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, ix, 2'b00};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy;
    rd = hrdata;
  endtask
  // Lock loaded: read-only, read-write and refused commands
  task automatic s_access;
    logic [31:0] c = 32'h103d502f;
    logic [7:0] e = 8'b10_11_00_11;
    for (int i = 0; i < 4; i++) begin
      smb_cmd <= c[31-8*i -: 8];
      tick(2);
      chk({cmd_rd_ok, cmd_wr_ok}, e[7-2*i -: 2]);
    end
  endtask
  // Option decodes, limit nibbles and cell faults
  task s_limits;
    chk(once_cnt, 1);
    chk(cell_high_limit, 4416);
    chk(cell_low_limit, 2368);
    chk(learn_current_floor, 187);
    chk(learn_cold_limit, 120);
    chk({display_source_select, compensated_threshold_enable,
      continuous_midrange_fix, external_thermistor_select,
      four_series_select}, 0);
    chk(discharge_end_basis, 0);
    cell_max_mv <= 5000;
    cell_min_mv <= 1000;
    tick(40);
    chk({cell_over_flag, cell_under_flag}, 2'b11);
    cell_max_mv <= 4000;
    cell_min_mv <= 3000;
    tick(40);
    chk({cell_over_flag, cell_under_flag}, 2'b00);
  endtask
  // Margin of two steps: at the edge, past it, far past it
  task s_overcur;
    fast_current_ma <= 1000;
    meas_current_ma <= 1032;
    charging <= 1'b1;
    tick(6);
    chk(charge_request_ma, 1000);
    meas_current_ma <= 1033;
    tick(4);
    chk(charge_request_ma, 0);
    meas_current_ma <= 6000;
    tick(4);
    chk(charge_request_ma, 0);
    charging <= 1'b0;
    tick(4);
  endtask
  // Taper hold of forty ticks, resync to half, flag clear
  task s_taper;
    meas_current_ma <= 100;
    charging <= 1'b1;
    tick(300);
    chk(full_flag, 0);
    for (n = 0; n < 300 && rm_load !== 1'b1; n++) tick(1);
    if (n == 300) begin
      error_cnt++;
      close_out;
    end
    chk(rm_load_value, 1000);
    tick(1);
    chk(full_flag, 1);
    charging <= 1'b0;
    rsoc <= 6;
    tick(3);
    chk(full_flag, 1);
    rsoc <= 5;
    tick(3);
    chk(full_flag, 0);
  endtask
  // Three mAh removed per counted cycle
  task s_cycle;
    chk(cycle_count, 0);
    for (int i = 1; i <= 7; i++) begin
      dsg_mah_pulse <= 1'b1;
      tick(1);
      dsg_mah_pulse <= 1'b0;
      tick(3);
      chk(cycle_count, i / 3);
    end
  endtask
  task s_alarm;
    run_time_min <= 10;
    remaining_capacity <= 100;
    tick(3);
    chk({time_alarm, capacity_alarm}, 2'b11);
    run_time_min <= 90;
    remaining_capacity <= 900;
    tick(3);
    chk({time_alarm, capacity_alarm}, 2'b00);
  endtask
  // Register map, an unmapped place and a read-only count
  task automatic s_regs;
    logic [31:0] r;
    logic [103:0] ix = 104'h02042e3c3f45494a4b4c4e4f63;
    logic [12:0] wide = 13'b1111000000000;
    bus(0, 8'h3f, 0, r);
    chk(r, 32'h62);
    for (int i = 0; i < 13; i++) begin
      bus(1, ix[103-8*i -: 8], 32'ha5c35a3c, r);
      bus(0, ix[103-8*i -: 8], 0, r);
      chk(r, wide[12-i] ? 32'h5a3c : 32'h3c);
    end
    bus(1, 8'h50, 32'hffff, r);
    bus(0, 8'h50, 0, r);
    chk(r, 0);
    bus(1, 8'h91, 32'h7, r);
    bus(0, 8'h91, 0, r);
    chk(r, 2);
    // Byte 0x3c now sits in both option bytes and the limit byte
    chk({display_source_select, compensated_threshold_enable,
      continuous_midrange_fix, external_thermistor_select,
      four_series_select}, 5'b01110);
    chk(discharge_end_basis, 1);
    chk(learn_current_floor, 62);
    chk(learn_cold_limit, 96);
    chk(hresp, 0);
  endtask
  // Cold window asks for precharge, hot limit suspends
  task s_temp;
    temp_dc <= 50;
    charging <= 1'b1;
    tick(4);
    chk(charge_request_ma, 100);
    temp_dc <= 642;
    tick(4);
    chk(charge_request_ma, 0);
  endtask
  initial begin
    tick(3);
    hresetn <= 1'b1;
    for (n = 0; n < 100 && ee_done !== 1'b1; n++) tick(1);
    if (n == 100) begin
      error_cnt++;
      close_out;
    end
    tick(2);
    s_access;
    s_limits;
    s_overcur;
    s_taper;
    s_cycle;
    s_alarm;
    s_regs;
    s_temp;
    close_out;
  end
endmodule
bind charge_control charge_control_asserts chk_i (.*);
